// >>> core/xlk_cfg.svh
// constants for the crossbar link block: sizes, pattern fields, reset values
`ifndef XLK_CFG_SVH
`define XLK_CFG_SVH
`define XLK_PORTS 8
`define XLK_NIB 4
`define XLK_BUS 32
`define XLK_FIFO_DEPTH 31
`define XLK_DLY_TAPS 31
`define XLK_ALMOST 2
`define XLK_PRF_STAGES 14
`define XLK_XSEL_LSB 0
`define XLK_XSEL_W 3
`define XLK_SHIFT_LSB 24
`define XLK_OSEL_LSB 32
`define XLK_OSEL_W 4
`define XLK_SEL_XBAR 4'hE
`define XLK_SEL_HIZ 4'hF
`define XLK_PAT_RST 64'hFFFF_FFFF_0000_0000
`define XLK_NIB_ZERO 4'h0
`define XLK_BYTE_ZERO 8'h00
`define XLK_DLY_ZERO 5'h00
`endif

// >>> core/xlk_pkg.sv
// types shared by the crossbar link block
package xlk_pkg;
    // role of one input stage; the spare code 3 behaves as a delay line
    typedef enum logic [1:0] {
        XLK_DELAY  = 2'h0,
        XLK_FIFO_A = 2'h1,
        XLK_FIFO_B = 2'h2
    } xlk_stage_mode_t;
    typedef logic [3:0] xlk_nib_t;
    typedef logic [63:0] xlk_pattern_t;
endpackage

// >>> core/xlk_top.sv
// crossbar link datapath: input stages, fifos, crossbar, pipeline register files
`timescale 1ns/1ps
`include "xlk_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// fifo shared by the input stages; width and depth shape its storage
module xlk_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic almost_full,
    output logic almost_empty
);
    import xlk_pkg::*;
    localparam int CW = $clog2(DEPTH + 1); // count width
    localparam int PW = $clog2(DEPTH); // pointer width
    localparam logic [CW-1:0] FULL_AT = CW'(DEPTH);
    localparam logic [CW-1:0] AF_AT = CW'(DEPTH - `XLK_ALMOST);
    localparam logic [CW-1:0] AE_AT = CW'(`XLK_ALMOST);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [0:DEPTH-1]; // storage, no reset needed
    logic [PW-1:0] wr_ptr_reg; // next slot to fill
    logic [PW-1:0] rd_ptr_reg; // head slot
    logic [CW-1:0] count_reg; // valid entries
    logic push;
    logic pop;
    logic [PW-1:0] wr_ptr_next;
    logic [PW-1:0] rd_ptr_next;

    // full ignores writes, empty ignores reads; contents stay put
    assign in_ready = (count_reg != FULL_AT);
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    // depth need not be a power of two, so pointers wrap explicitly
    assign wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + PW'(1);
    assign rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + PW'(1);
    // early warnings leave the controllers two items of slack
    assign almost_full = (count_reg >= AF_AT);
    assign almost_empty = (count_reg <= AE_AT);

    // storage write, only on an accepted push
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_next;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_next;
            end
            // simultaneous push and pop leaves the count alone
            if (push && !pop) begin
                count_reg <= count_reg + CW'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CW'(1);
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// How it works
// - one nibble in and out per port per cycle
// - input stage before, register file after crossbar
// - register files shift; output picks any stage
// - up to two fifos, A and B
// - fifo width in nibble steps, thirty-two bits max
// - unassigned stages are programmable delay lines
// - almost-empty flag per fifo
// - almost-full flag per fifo
// - flags assert early, before truly full/empty
// - new sixty-four bit pattern every cycle
// - control code port is bidirectional
// - each data output can float independently
// - almost full at two or fewer free
// - almost empty at two or fewer held
// - fifos hold 31; delay 0 to 31
// - at least two cycles input to output
module xlk_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out,
    output logic [7:0] data_out_oe,
    input wire logic [4:0] pattern_addr,
    input wire logic fifo_a_write_req,
    input wire logic fifo_b_write_req,
    input wire logic fifo_a_read_req,
    input wire logic fifo_b_read_req,
    output logic fifo_a_almost_full,
    output logic fifo_b_almost_full,
    output logic fifo_a_almost_empty,
    output logic fifo_b_almost_empty,
    input wire xlk_pkg::xlk_stage_mode_t [7:0] stage_mode,
    input wire logic [39:0] delay_len,
    input wire logic [7:0] ctrl_code_in,
    output logic [7:0] ctrl_code_out,
    output logic ctrl_code_oe,
    input wire logic ctrl_shift_in,
    input wire logic ctrl_shift_out,
    input wire logic ctrl_store,
    input wire logic bank_swap
);
    import xlk_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [31:0] in_reg; // input capture, first cycle of latency
    logic wr_a_reg; // write requests aligned with in_reg
    logic wr_b_reg;
    xlk_pattern_t pat_mem_reg [0:63]; // two banks of 32 patterns
    xlk_pattern_t pat_reg; // pattern steering this cycle
    xlk_pattern_t shift_reg; // byte-wide load/unload shifter
    logic bank_reg; // active bank
    logic [7:0] code_out_reg;
    logic code_oe_reg;
    logic [31:0] wr_mask_a; // nibble lanes belonging to fifo A
    logic [31:0] wr_mask_b;
    logic [31:0] head_a; // fifo heads, one nibble per member lane
    logic [31:0] head_b;
    logic af_a;
    logic af_b;
    logic ae_a;
    logic ae_b;
    logic ready_a;
    logic ready_b;
    logic flag_af_a_reg;
    logic flag_af_b_reg;
    logic flag_ae_a_reg;
    logic flag_ae_b_reg;
    xlk_nib_t stage_out [0:7]; // outputs of the eight input stages
    logic [5:0] pat_rd_addr;
    logic [5:0] pat_wr_addr;

    ////////////////////////////////////////////////////////////////////////////
    // input capture; every port takes a nibble each cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            in_reg <= '0;
            wr_a_reg <= 1'b0;
            wr_b_reg <= 1'b0;
        end else begin
            in_reg <= data_in;
            wr_a_reg <= fifo_a_write_req;
            wr_b_reg <= fifo_b_write_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the two fifos; members are chosen per lane, so width steps by a nibble
    // and eight lanes cap the total at thirty-two bits
    xlk_fifo #(
        .WIDTH(`XLK_BUS),
        .DEPTH(`XLK_FIFO_DEPTH)
    ) u_fifo_a (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(wr_a_reg),
        .in_data(in_reg & wr_mask_a),
        .in_ready(ready_a),
        .out_valid(),
        .out_data(head_a),
        .out_ready(fifo_a_read_req),
        .almost_full(af_a),
        .almost_empty(ae_a)
    );

    xlk_fifo #(
        .WIDTH(`XLK_BUS),
        .DEPTH(`XLK_FIFO_DEPTH)
    ) u_fifo_b (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(wr_b_reg),
        .in_data(in_reg & wr_mask_b),
        .in_ready(ready_b),
        .out_valid(),
        .out_data(head_b),
        .out_ready(fifo_b_read_req),
        .almost_full(af_b),
        .almost_empty(ae_b)
    );

    // status flags; full flags are also forced while the fifo refuses writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flag_af_a_reg <= 1'b0;
            flag_af_b_reg <= 1'b0;
            flag_ae_a_reg <= 1'b1;
            flag_ae_b_reg <= 1'b1;
        end else begin
            flag_af_a_reg <= af_a || !ready_a;
            flag_af_b_reg <= af_b || !ready_b;
            flag_ae_a_reg <= ae_a;
            flag_ae_b_reg <= ae_b;
        end
    end
    assign fifo_a_almost_full = flag_af_a_reg;
    assign fifo_b_almost_full = flag_af_b_reg;
    assign fifo_a_almost_empty = flag_ae_a_reg;
    assign fifo_b_almost_empty = flag_ae_b_reg;

    ////////////////////////////////////////////////////////////////////////////
    // input stages: fifo member or delay line, one per port
    genvar gi;
    generate
        for (gi = 0; gi < `XLK_PORTS; gi++) begin : g_stage
            xlk_nib_t dly_reg [0:`XLK_DLY_TAPS-1]; // delay taps
            logic [4:0] len;
            xlk_nib_t dly_out;
            logic is_a;
            logic is_b;
            assign len = delay_len[gi*5 +: 5];
            assign is_a = (stage_mode[gi] == XLK_FIFO_A);
            assign is_b = (stage_mode[gi] == XLK_FIFO_B);
            assign wr_mask_a[gi*4 +: 4] = {4{is_a}};
            assign wr_mask_b[gi*4 +: 4] = {4{is_b}};
            // length zero passes the captured nibble straight on
            assign dly_out = (len == `XLK_DLY_ZERO) ? in_reg[gi*4 +: 4]
                                                   : dly_reg[len - 5'h01];
            // stage selection; an unused code falls back to delay
            assign stage_out[gi] = is_a ? head_a[gi*4 +: 4] :
                                   is_b ? head_b[gi*4 +: 4] : dly_out;
            // tapped shift line, runs every cycle
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    for (int i = 0; i < `XLK_DLY_TAPS; i++) begin
                        dly_reg[i] <= `XLK_NIB_ZERO;
                    end
                end else begin
                    dly_reg[0] <= in_reg[gi*4 +: 4];
                    for (int i = 1; i < `XLK_DLY_TAPS; i++) begin
                        dly_reg[i] <= dly_reg[i-1];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // pattern memory: patterns load into the idle bank while the other runs
    assign pat_rd_addr = {bank_reg, pattern_addr};
    assign pat_wr_addr = {~bank_reg, pattern_addr};

    // memory write of the assembled pattern
    always_ff @(posedge sys_clk) begin
        if (ctrl_store) begin
            pat_mem_reg[pat_wr_addr] <= shift_reg;
        end
    end

    // pattern register, bank select and control code shifter
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pat_reg <= `XLK_PAT_RST; // every output floats after reset
            bank_reg <= 1'b0;
            shift_reg <= '0;
            code_out_reg <= `XLK_BYTE_ZERO;
            code_oe_reg <= 1'b0;
        end else begin
            pat_reg <= pat_mem_reg[pat_rd_addr];
            if (bank_swap) begin
                bank_reg <= ~bank_reg;
            end
            // the code port drives out only while unloading
            code_oe_reg <= ctrl_shift_out;
            if (ctrl_shift_out) begin
                code_out_reg <= shift_reg[63:56];
                shift_reg <= {shift_reg[55:0], `XLK_BYTE_ZERO};
            end else if (ctrl_shift_in) begin
                shift_reg <= {shift_reg[55:0], ctrl_code_in};
            end
        end
    end
    assign ctrl_code_out = code_out_reg;
    assign ctrl_code_oe = code_oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // crossbar and pipeline register files, one per output port
    genvar go;
    generate
        for (go = 0; go < `XLK_PORTS; go++) begin : g_out
            xlk_nib_t prf_reg [0:`XLK_PRF_STAGES-1]; // shifting stages
            xlk_nib_t xbar;
            xlk_nib_t dout_next;
            xlk_nib_t dout_reg;
            logic oe_reg;
            logic [2:0] xsel;
            logic [3:0] osel;
            logic shift_en;
            assign xsel = pat_reg[`XLK_XSEL_LSB + go*`XLK_XSEL_W +: `XLK_XSEL_W];
            assign osel = pat_reg[`XLK_OSEL_LSB + go*`XLK_OSEL_W +: `XLK_OSEL_W];
            assign shift_en = pat_reg[`XLK_SHIFT_LSB + go];
            assign xbar = stage_out[xsel];
            // random access into the pipe, or the live crossbar value
            assign dout_next = (osel == `XLK_SEL_XBAR) ? xbar :
                               (osel < `XLK_SEL_XBAR) ? prf_reg[osel] : `XLK_NIB_ZERO;
            // stage shift, only when the pattern asks for it
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    for (int i = 0; i < `XLK_PRF_STAGES; i++) begin
                        prf_reg[i] <= `XLK_NIB_ZERO;
                    end
                end else if (shift_en) begin
                    prf_reg[0] <= xbar;
                    for (int i = 1; i < `XLK_PRF_STAGES; i++) begin
                        prf_reg[i] <= prf_reg[i-1];
                    end
                end
            end
            // output register: second latency cycle, so data never crosses
            // in under two edges; the float choice is per port
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    dout_reg <= `XLK_NIB_ZERO;
                    oe_reg <= 1'b0;
                end else begin
                    dout_reg <= dout_next;
                    oe_reg <= (osel != `XLK_SEL_HIZ);
                end
            end
            assign data_out[go*4 +: 4] = dout_reg;
            assign data_out_oe[go] = oe_reg;
        end
    endgenerate
endmodule

// >>> verif/xlk_top_properties.sv
// assertions on the ports of the crossbar link top
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module xlk_top_checker (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [31:0] data_out,
    input wire logic [7:0] data_out_oe,
    input wire logic fifo_a_write_req,
    input wire logic fifo_a_read_req,
    input wire logic fifo_a_almost_full,
    input wire logic fifo_a_almost_empty,
    input wire logic fifo_b_almost_full,
    input wire logic fifo_b_almost_empty,
    input wire logic ctrl_code_oe,
    input wire logic ctrl_shift_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // nothing may drive on the first edge after reset
    AST_RESET_QUIET: assert property ($rose(nrst) |->
        data_out_oe == 8'h00 && !ctrl_code_oe)
        else $error("outputs driven right after reset");
    AST_RESET_FLAGS: assert property ($rose(nrst) |->
        fifo_a_almost_empty && !fifo_a_almost_full)
        else $error("fifo flags wrong after reset");
    // a floating lane reads zero; lane 0 only, so unloaded patterns stay vacuous
    AST_FLOAT_ZERO: assert property (!data_out_oe[0] |-> data_out[3:0] == 4'h0)
        else $error("floating lane carries data");
    // 31 deep: two or fewer held and two or fewer free never meet
    AST_FLAG_EXCL: assert property (!(fifo_a_almost_full && fifo_a_almost_empty))
        else $error("almost full and almost empty together");
    AST_AE_FALL: assert property ($fell(fifo_a_almost_empty) |->
        $past(fifo_a_write_req, 2) || $past(fifo_a_write_req, 3))
        else $error("almost empty fell without a push");
    AST_AF_RISE: assert property ($rose(fifo_a_almost_full) |->
        $past(fifo_a_write_req, 2) || $past(fifo_a_write_req, 3))
        else $error("almost full rose without a push");
    AST_AF_FALL: assert property ($fell(fifo_a_almost_full) |->
        $past(fifo_a_read_req, 2) || $past(fifo_a_read_req, 3))
        else $error("almost full fell without a pop");
    // with no requests the count, hence the flags, must hold
    AST_FLAG_HOLD: assert property ((!fifo_a_write_req && !fifo_a_read_req) [*4] |=>
        $stable(fifo_a_almost_empty) && $stable(fifo_a_almost_full))
        else $error("fifo flag moved while idle");
    AST_CODE_OE: assert property (ctrl_shift_out |=> ctrl_code_oe)
        else $error("code port not driven on unload");
    AST_CODE_CAUSE: assert property (ctrl_code_oe |-> $past(ctrl_shift_out))
        else $error("code port driven without unload");
    COV_AE_FALL: cover property ($fell(fifo_a_almost_empty));
    COV_AF_RISE: cover property ($rose(fifo_a_almost_full));
    COV_B_FALL: cover property ($fell(fifo_b_almost_empty));
    COV_CODE: cover property (ctrl_code_oe);
endmodule
////////////////////////////////////////////////////////////////
bind xlk_top xlk_top_checker chk (.sys_clk, .nrst, .data_out, .data_out_oe,
    .fifo_a_write_req, .fifo_a_read_req, .fifo_a_almost_full, .fifo_a_almost_empty,
    .fifo_b_almost_full, .fifo_b_almost_empty, .ctrl_code_oe, .ctrl_shift_out);

// >>> verif/xlk_ctrl_model.sv
// controller model: pattern address, fifo requests, code port loading
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module xlk_ctrl_model (
    input wire logic sys_clk,
    input wire logic [7:0] ctrl_code_out,
    input wire logic ctrl_code_oe,
    output logic [7:0] ctrl_code_in,
    output logic [4:0] pattern_addr,
    output logic fifo_a_write_req,
    output logic fifo_b_write_req,
    output logic fifo_a_read_req,
    output logic fifo_b_read_req,
    output logic ctrl_shift_in,
    output logic ctrl_shift_out,
    output logic ctrl_store,
    output logic bank_swap
);
    logic [7:0] drv; // byte the controller puts on the shared code lines
    // the block wins the shared lines while it drives them
    assign ctrl_code_in = ctrl_code_oe ? ctrl_code_out : drv;
    initial begin
        drv = 8'h00;
        {pattern_addr, fifo_a_write_req, fifo_b_write_req, fifo_a_read_req} = '0;
        {fifo_b_read_req, ctrl_shift_in, ctrl_shift_out, ctrl_store, bank_swap} = '0;
    end
    // one cycle of requests; caller stands at a falling edge
    task automatic req(input logic [4:0] pa, input logic [3:0] r);
        pattern_addr = pa;
        {fifo_a_write_req, fifo_b_write_req} = r[3:2];
        {fifo_a_read_req, fifo_b_read_req} = r[1:0];
    endtask
    // shift a pattern in top byte first, optionally store it in the idle bank
    task automatic load(input logic [4:0] a, input logic [63:0] p, input logic st);
        for (int i = 7; i >= 0; i--) begin
            @(negedge sys_clk);
            ctrl_shift_in = 1'b1;
            drv = p[8*i+:8];
        end
        @(negedge sys_clk);
        ctrl_shift_in = 1'b0;
        drv = ~drv; // released lines must not look like the last byte
        ctrl_store = st;
        pattern_addr = a;
        @(negedge sys_clk);
        ctrl_store = 1'b0;
    endtask
    // make the freshly loaded bank the active one
    task automatic swap();
        @(negedge sys_clk);
        bank_swap = 1'b1;
        @(negedge sys_clk);
        bank_swap = 1'b0;
    endtask
    // read the top two bytes back out of the shifter
    task automatic unload(output logic [7:0] b0, output logic [7:0] b1, output logic oe);
        @(negedge sys_clk);
        ctrl_shift_out = 1'b1;
        @(negedge sys_clk);
        b0 = ctrl_code_out;
        oe = ctrl_code_oe;
        @(negedge sys_clk);
        ctrl_shift_out = 1'b0;
        b1 = ctrl_code_out;
    endtask
endmodule

// >>> verif/xlk_top_tb.sv
// self-checking bench for the crossbar link top
`timescale 1ns/1ps
module xlk_top_tb;
    import xlk_pkg::*;
    logic sys_clk, nrst, code_oe, sh_in, sh_out, store, swap, wa, wb, ra, rb;
    logic afa, afb, aea, aeb;
    logic [31:0] data_in, data_out;
    logic [7:0] data_out_oe, code_in, code_out;
    logic [4:0] pattern_addr;
    xlk_stage_mode_t [7:0] stage_mode;
    logic [7:0] q[2][$]; // expected contents of fifo A and B
    int num_errors = 0, total_checks = 0, cycles = 0;
    xlk_ctrl_model ctl (.sys_clk, .ctrl_code_out(code_out), .ctrl_code_oe(code_oe),
        .ctrl_code_in(code_in), .pattern_addr, .fifo_a_write_req(wa), .fifo_b_write_req(wb),
        .fifo_a_read_req(ra), .fifo_b_read_req(rb), .ctrl_shift_in(sh_in),
        .ctrl_shift_out(sh_out), .ctrl_store(store), .bank_swap(swap));
    // lane 3 is a five-cycle delay; other non-fifo lanes have none
    xlk_top DUT (.sys_clk, .nrst, .data_in, .data_out, .data_out_oe, .pattern_addr,
        .fifo_a_write_req(wa), .fifo_b_write_req(wb), .fifo_a_read_req(ra),
        .fifo_b_read_req(rb), .fifo_a_almost_full(afa), .fifo_b_almost_full(afb),
        .fifo_a_almost_empty(aea), .fifo_b_almost_empty(aeb), .stage_mode,
        .delay_len(40'h00_0002_8000), .ctrl_code_in(code_in), .ctrl_code_out(code_out),
        .ctrl_code_oe(code_oe), .ctrl_shift_in(sh_in), .ctrl_shift_out(sh_out),
        .ctrl_store(store), .bank_swap(swap));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // 0: identity, all via crossbar; 1: lanes 7..4 on each half, lane 0 floats; 2: taps 0, 3, 13
    function automatic logic [63:0] pat(input int k);
        logic [63:0] p;
        p = {32'hEEEE_EEEE, 8'hFF, 24'h0};
        for (int o = 0; o < 8; o++) p[3*o+:3] = (k == 1) ? 3'(7 - o % 4) : 3'(o);
        if (k == 1) p[35:32] = 4'hF;
        if (k == 2) p[63:32] = 32'hED30_EEEE;
        return p;
    endfunction
    task automatic code_test();
        logic [7:0] b0, b1;
        logic oe;
        ctl.load(5'h00, 64'hA5C3_0000_0000_0000, 1'b0);
        ctl.unload(b0, b1, oe);
        check({oe, b0, b1}, {1'b1, 16'hA5C3});
    endtask
    // pattern 1 every third cycle, pattern 0 otherwise; lanes 4..7 and delayed lane 3 checked
    task automatic stream_test();
        logic [31:0] hd[$];
        logic [4:0] hp[$];
        logic [3:0] e;
        for (int t = 0; t < 40; t++) begin
            @(negedge sys_clk);
            if (t >= 7) begin
                for (int o = 4; o < 8; o++) begin
                    e = hd[t-2][4*((hp[t-2] == 5'h01) ? 11 - o : o)+:4];
                    check(data_out[4*o+:4], e);
                end
                check(data_out_oe[0], hp[t-2] != 5'h01);
                if (hp[t-2] == 5'h00) check(data_out[15:12], hd[t-7][15:12]);
            end
            hd.push_back({8{4'(t)}} ^ 32'h7654_3210);
            hp.push_back((t % 3 == 1) ? 5'h01 : 5'h00);
            data_in = hd[t];
            ctl.req(hp[t], 4'h0);
        end
    endtask
    // a counting stream makes the age gap between taps visible
    task automatic prf_test();
        for (int t = 0; t < 24; t++) begin
            @(negedge sys_clk);
            if (t > 18) begin
                check(4'(data_out[19:16] - data_out[23:20]), 4'h3);
                check(4'(data_out[19:16] - data_out[27:24]), 4'hD);
            end
            data_in = {8{4'(t)}};
            ctl.req(5'h02, 4'h0);
        end
    endtask
    // one request, then settle and compare flags and head against the queue
    task automatic fifo_op(input bit b, input bit wr, input bit rd, input logic [7:0] v);
        @(negedge sys_clk);
        data_in = {20'h0, v[3:0], v};
        ctl.req(5'h00, b ? {1'b0, wr, 1'b0, rd} : {wr, 1'b0, rd, 1'b0});
        @(negedge sys_clk);
        ctl.req(5'h00, 4'h0);
        repeat (3) @(negedge sys_clk);
        if (wr && q[b].size() < 31) q[b].push_back(v);
        if (rd && q[b].size() > 0) void'(q[b].pop_front());
        check(b ? aeb : aea, q[b].size() <= 2);
        check(b ? afb : afa, q[b].size() >= 29);
        if (q[b].size() > 0) begin
            check(b ? data_out[11:8] : data_out[7:0], b ? q[b][0][3:0] : q[b][0]);
        end
    endtask
    task automatic fifo_test();
        for (int i = 0; i < 34; i++) fifo_op(0, 1, 0, 8'(8'h40 + i));
        for (int i = 0; i < 33; i++) fifo_op(0, 0, 1, 8'h00);
        fifo_op(0, 1, 0, 8'h5A);
        for (int i = 0; i < 5; i++) fifo_op(1, i < 3, i >= 3, 8'(i + 1));
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // the whole run needs about 500 cycles; a hang is cut well after that
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        nrst = 1'b0;
        data_in = 32'h0;
        for (int i = 0; i < 8; i++) begin
            stage_mode[i] = (i < 2) ? XLK_FIFO_A : ((i == 2) ? XLK_FIFO_B : XLK_DELAY);
        end
        repeat (16) @(negedge sys_clk);
        check({data_out_oe, aea, afa}, 10'h002);
        nrst = 1'b1;
        code_test();
        for (int k = 0; k < 3; k++) ctl.load(5'(k), pat(k), 1'b1);
        ctl.swap();
        stream_test();
        prf_test();
        fifo_test();
        print_verdict();
    end
endmodule
